// *** rtl/ecfd_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecfd_edge
  import ecfd_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       srst,
  input  wire logic       pin,
  input  wire logic       sample_tick,
  input  wire logic       filter_en,
  input  wire logic [1:0] edge_sel,
  output logic            valid_edge
);

  logic sync1;
  logic sync2;
  logic samp;
  logic filt;
  logic next_filt;
  logic rise;
  logic fall;

  // ****************************************
  // synchroniser, then filter on the op clock
  // ****************************************
  always_ff @(posedge aclk) begin
    if (srst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // filter wants two equal samples in a row before a level is accepted
  always_comb begin
    next_filt = filt;
    if (sample_tick && (!filter_en || samp == sync2)) begin
      next_filt = sync2;
    end
    rise = next_filt && !filt;
    fall = !next_filt && filt;
  end

  always_ff @(posedge aclk) begin
    if (srst) begin
      samp       <= 1'b0;
      filt       <= 1'b0;
      valid_edge <= 1'b0;
    end else begin
      if (sample_tick) begin
        samp <= sync2;
      end
      filt <= next_filt;
      unique case (edge_sel)
        ecfd_edge_fall: valid_edge <= fall;
        ecfd_edge_rise: valid_edge <= rise;
        ecfd_edge_both: valid_edge <= rise || fall;
        default:        valid_edge <= rise;
      endcase
    end
  end

endmodule // ecfd_edge
`default_nettype wire

// *** rtl/ecfd_pkg.sv ***
package ecfd_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH    = 4;
  localparam int CNT_W     = 16;
  localparam int LOW_W     = 8;
  localparam int ADDR_W    = 8;
  localparam int PS_W      = 4;
  localparam int PSC_W     = 16;
  localparam int MODE_W    = 9;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_PERIPH    = 8'h00;
  localparam logic [7:0] OFF_PRESCALE  = 8'h04;
  localparam logic [7:0] OFF_START     = 8'h08;
  localparam logic [7:0] OFF_STOP      = 8'h0c;
  localparam logic [7:0] OFF_ACTIVE    = 8'h10;
  localparam logic [7:0] OFF_OUT_LEVEL = 8'h14;
  localparam logic [7:0] OFF_TOGGLE_EN = 8'h18;
  localparam logic [7:0] OFF_OUT_MODE  = 8'h1c;
  localparam logic [7:0] OFF_OUT_POL   = 8'h20;
  localparam logic [7:0] OFF_FILTER    = 8'h24;
  // channel block: addr[7:6] region, addr[5:4] channel, addr[3:2] register
  localparam logic [1:0] CH_REGION     = 2'h1;
  localparam logic [1:0] CH_SUB_MODE   = 2'h0;
  localparam logic [1:0] CH_SUB_DATA   = 2'h1;
  localparam logic [1:0] CH_SUB_COUNT  = 2'h2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int UNIT_EN_BIT   = 0;
  localparam int PS_A_LSB      = 0;
  localparam int PS_B_LSB      = 4;
  localparam int MODE_SIS_BIT  = 0;
  localparam int MODE_CKS_BIT  = 1;
  localparam int MODE_EDGE_LSB = 2;
  localparam int MODE_FUNC_LSB = 4;
  localparam int MODE_SPLIT_BIT = 8;

  // ****************************************
  // reset values and channel capabilities
  // ****************************************
  localparam logic [MODE_W-1:0] MODE_RST  = 9'h000;
  localparam logic [CNT_W-1:0]  DATA_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  COUNT_RST = 16'hffff;
  localparam logic [CNT_W-1:0]  COUNT_ZERO = 16'h0000;
  localparam logic [LOW_W-1:0]  LOW_ZERO  = 8'h00;
  localparam logic [7:0]        PSC_RST   = 8'h00;
  localparam logic [3:0]        CH_RST    = 4'h0;
  localparam logic [3:0]        DIV_CH_MASK   = 4'h9;
  localparam logic [3:0]        SPLIT_CH_MASK = 4'ha;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ecfd_func_off    = 3'b000,
    ecfd_func_event  = 3'b001,
    ecfd_func_divide = 3'b010
  } ecfd_func_t;

  typedef enum logic [1:0] {
    ecfd_edge_fall = 2'b00,
    ecfd_edge_rise = 2'b01,
    ecfd_edge_both = 2'b10
  } ecfd_edge_t;

endpackage

// *** rtl/ecfd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecfd_top
  import ecfd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NUM_CH-1:0] event_input_pin,
  output logic [NUM_CH-1:0]      timer_out,
  output logic [NUM_CH-1:0]      channel_interrupt
);

  // ****************************************
  // declarations
  // ****************************************
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              aw_held;
  logic              w_held;
  logic              wr_fire;
  logic              wr_hit;
  logic [31:0]       rd_data;
  logic              rd_hit;
  logic [31:0]       wr_mask;
  logic              unit_en;
  logic              unit_rst;
  logic              unit_wr;
  logic [7:0]        prescale_r;
  logic [PSC_W-1:0]  psc_cnt;
  logic [PSC_W-1:0]  mask_a;
  logic [PSC_W-1:0]  mask_b;
  logic              tick_a;
  logic              tick_b;
  logic [NUM_CH-1:0] active_r;
  logic [NUM_CH-1:0] level_r;
  logic [NUM_CH-1:0] toggle_en_r;
  logic [NUM_CH-1:0] out_mode_r;
  logic [NUM_CH-1:0] out_pol_r;
  logic [NUM_CH-1:0] filter_r;
  logic [NUM_CH-1:0] start_p;
  logic [NUM_CH-1:0] stop_p;
  logic [NUM_CH-1:0] edge_p;
  logic [NUM_CH-1:0] tog_p;
  logic [NUM_CH-1:0] irq_p;
  logic [MODE_W-1:0] mode_r  [NUM_CH];
  logic [CNT_W-1:0]  data_r  [NUM_CH];
  logic [CNT_W-1:0]  count_r [NUM_CH];
  logic [31:0]       wr_merged;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= '0;
      wr_strb      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte lanes merged into the stored value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_mask[b*8 +: 8] = {8{wr_strb[b]}};
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (wr_addr[7:6] == CH_REGION) begin
      wr_hit = (wr_addr[3:2] != 2'h3) && (wr_addr[1:0] == 2'h0);
    end else begin
      unique case (wr_addr)
        OFF_PERIPH, OFF_PRESCALE, OFF_START, OFF_STOP, OFF_ACTIVE,
        OFF_OUT_LEVEL, OFF_TOGGLE_EN, OFF_OUT_MODE, OFF_OUT_POL,
        OFF_FILTER: wr_hit = 1'b1;
        default:    wr_hit = 1'b0;
      endcase
    end
  end

  // writes to timer registers only land while the unit is powered
  assign unit_wr = wr_fire && wr_hit && unit_en;

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    if (s_axi_araddr[7:6] == CH_REGION) begin
      rd_hit = (s_axi_araddr[3:2] != 2'h3) && (s_axi_araddr[1:0] == 2'h0);
      if (unit_en) begin
        unique case (s_axi_araddr[3:2])
          CH_SUB_MODE:  rd_data[MODE_W-1:0] = mode_r[s_axi_araddr[5:4]];
          CH_SUB_DATA:  rd_data[CNT_W-1:0]  = data_r[s_axi_araddr[5:4]];
          CH_SUB_COUNT: rd_data[CNT_W-1:0]  = count_r[s_axi_araddr[5:4]];
          default:      rd_data = '0;
        endcase
      end
    end else begin
      unique case (s_axi_araddr)
        OFF_PERIPH:    rd_data[UNIT_EN_BIT] = unit_en;
        OFF_PRESCALE:  rd_data[7:0] = unit_en ? prescale_r : PSC_RST;
        OFF_START:     rd_data = '0;
        OFF_STOP:      rd_data = '0;
        OFF_ACTIVE:    rd_data[3:0] = unit_en ? active_r : CH_RST;
        OFF_OUT_LEVEL: rd_data[3:0] = unit_en ? level_r : CH_RST;
        OFF_TOGGLE_EN: rd_data[3:0] = unit_en ? toggle_en_r : CH_RST;
        OFF_OUT_MODE:  rd_data[3:0] = unit_en ? out_mode_r : CH_RST;
        OFF_OUT_POL:   rd_data[3:0] = unit_en ? out_pol_r : CH_RST;
        OFF_FILTER:    rd_data[3:0] = unit_en ? filter_r : CH_RST;
        default:       rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // unit enable and prescaler
  // ****************************************
  // no gated clock here: a disabled unit is held in reset instead
  assign unit_rst = !aresetn || !unit_en;

  assign wr_merged = wr_data & wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_en <= 1'b0;
    end else if (wr_fire && wr_addr == OFF_PERIPH && wr_strb[0]) begin
      unit_en <= wr_data[UNIT_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      prescale_r <= PSC_RST;
    end else if (unit_wr && wr_addr == OFF_PRESCALE && wr_strb[0]) begin
      prescale_r <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      psc_cnt <= '0;
    end else begin
      psc_cnt <= psc_cnt + 16'h0001;
    end
  end

  assign mask_a = (16'h0001 << prescale_r[PS_A_LSB +: PS_W]) - 16'h0001;
  assign mask_b = (16'h0001 << prescale_r[PS_B_LSB +: PS_W]) - 16'h0001;
  // op clocks are strobes of 2^n cycles; input sampling follows them
  assign tick_a = (psc_cnt & mask_a) == mask_a;
  assign tick_b = (psc_cnt & mask_b) == mask_b;

  // ****************************************
  // triggers and shared per-channel bits
  // ****************************************
  // trigger registers store nothing, so they always read back as zero
  assign start_p = (unit_wr && wr_addr == OFF_START && wr_strb[0]) ? wr_data[3:0] : CH_RST;
  assign stop_p  = (unit_wr && wr_addr == OFF_STOP && wr_strb[0]) ? wr_data[3:0] : CH_RST;

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      active_r <= CH_RST;
    end else begin
      active_r <= (active_r | start_p) & ~stop_p;
    end
  end

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      toggle_en_r <= CH_RST;
      out_mode_r  <= CH_RST;
      out_pol_r   <= CH_RST;
      filter_r    <= CH_RST;
    end else if (unit_wr && wr_strb[0]) begin
      unique case (wr_addr)
        OFF_TOGGLE_EN: toggle_en_r <= wr_data[3:0];
        OFF_OUT_MODE:  out_mode_r  <= wr_data[3:0];
        OFF_OUT_POL:   out_pol_r   <= wr_data[3:0];
        OFF_FILTER:    filter_r    <= wr_data[3:0];
        default:       filter_r    <= filter_r;
      endcase
    end
  end

  // a hardware toggle lands on top of a same-cycle software write
  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      level_r <= CH_RST;
    end else if (unit_wr && wr_addr == OFF_OUT_LEVEL && wr_strb[0]) begin
      level_r <= wr_data[3:0] ^ (tog_p & toggle_en_r);
    end else begin
      // a stop leaves the level where it was
      level_r <= level_r ^ (tog_p & toggle_en_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (unit_rst) begin
      timer_out <= CH_RST;
    end else begin
      timer_out <= level_r ^ (out_pol_r & out_mode_r);
    end
  end

  assign channel_interrupt = irq_p;

  // ****************************************
  // channels
  // ****************************************
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    ecfd_func_t        func;
    logic              is_evt;
    logic              is_div;
    logic              split;
    logic              cnt_zero;
    logic              wait_first;
    logic              ch_sel;
    logic [CNT_W-1:0]  reload;
    logic [CNT_W-1:0]  dec;

    ecfd_edge u_edge (
      .aclk        (aclk),
      .srst        (unit_rst),
      .pin         (event_input_pin[n]),
      .sample_tick (mode_r[n][MODE_CKS_BIT] ? tick_b : tick_a),
      .filter_en   (filter_r[n]),
      .edge_sel    (mode_r[n][MODE_EDGE_LSB +: 2]),
      .valid_edge  (edge_p[n])
    );

    assign func   = ecfd_func_t'(mode_r[n][MODE_FUNC_LSB +: 3]);
    assign is_evt = func == ecfd_func_event;
    assign is_div = (func == ecfd_func_divide) && DIV_CH_MASK[n];
    assign split  = mode_r[n][MODE_SPLIT_BIT] && SPLIT_CH_MASK[n];
    assign ch_sel = unit_wr && wr_addr[7:6] == CH_REGION && wr_addr[5:4] == 2'(n);

    // split mode keeps the upper byte frozen
    assign cnt_zero = split ? (count_r[n][LOW_W-1:0] == LOW_ZERO)
                            : (count_r[n] == COUNT_ZERO);
    assign reload   = split ? {count_r[n][CNT_W-1:LOW_W], data_r[n][LOW_W-1:0]}
                            : data_r[n];
    assign dec      = split ? {count_r[n][CNT_W-1:LOW_W],
                               count_r[n][LOW_W-1:0] - LOW_ZERO - 8'h01}
                            : count_r[n] - 16'h0001;

    always_ff @(posedge aclk) begin
      if (unit_rst) begin
        mode_r[n] <= MODE_RST;
        data_r[n] <= DATA_RST;
      end else if (ch_sel && wr_addr[3:2] == CH_SUB_MODE) begin
        mode_r[n] <= MODE_W'((mode_r[n] & ~MODE_W'(wr_mask)) | MODE_W'(wr_merged));
      end else if (ch_sel && wr_addr[3:2] == CH_SUB_DATA) begin
        // count only picks this up at its next reload
        data_r[n] <= CNT_W'((data_r[n] & ~CNT_W'(wr_mask)) | CNT_W'(wr_merged));
      end
    end

    always_ff @(posedge aclk) begin
      if (unit_rst) begin
        count_r[n] <= COUNT_RST;
        wait_first <= 1'b0;
        irq_p[n]   <= 1'b0;
        tog_p[n]   <= 1'b0;
      end else begin
        irq_p[n] <= 1'b0;
        tog_p[n] <= 1'b0;
        if (stop_p[n]) begin
          wait_first <= 1'b0;
        end else if (start_p[n]) begin
          if (is_div) begin
            wait_first <= 1'b1;
          end else if (is_evt) begin
            count_r[n] <= reload;
          end
        end else if (active_r[n] && edge_p[n]) begin
          if (wait_first) begin
            count_r[n] <= reload;
            wait_first <= 1'b0;
            irq_p[n]   <= mode_r[n][MODE_SIS_BIT];
            tog_p[n]   <= mode_r[n][MODE_SIS_BIT];
          end else if (is_evt || is_div) begin
            if (cnt_zero) begin
              count_r[n] <= reload;
              irq_p[n]   <= 1'b1;
              tog_p[n]   <= is_div;
            end else begin
              count_r[n] <= dec;
            end
          end
        end
      end
    end
  end

endmodule // ecfd_top
`default_nettype wire

// *** testbench/ecfd_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external event source
// ****************************************
module ecfd_src (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [3:0] mask,
  input  wire logic [7:0] n_pulses,
  output logic            busy,
  output logic [3:0]      event_input_pin
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph   = 3'h0;
  // idle low; 8-cycle period keeps edges far apart from the sync delay
  assign busy = (left != 8'h00);
  assign event_input_pin = (busy && ph[2]) ? mask : 4'h0;
  always @(posedge aclk) begin
    if (go && !busy) begin
      left <= n_pulses;
      ph <= 3'h0;
    end else if (busy) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7)
        left <= left - 8'h01;
    end
  end
endmodule // ecfd_src
`default_nettype wire

// *** testbench/ecfd_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module ecfd_sva
  import ecfd_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [NUM_CH-1:0] event_input_pin,
  input wire logic [NUM_CH-1:0] timer_out,
  input wire logic [NUM_CH-1:0] channel_interrupt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ages saturate at 15; bounds assume prescaler 0 and filter off
  logic [NUM_CH-1:0] pin_q;
  logic [3:0]        pin_age [NUM_CH];
  logic [3:0]        irq_age [NUM_CH];
  logic [3:0]        b_age;
  always_ff @(posedge aclk) begin
    pin_q <= event_input_pin;
    if (!aresetn)
      b_age <= 4'hf;
    else if (s_axi_bvalid)
      b_age <= 4'h0;
    else if (b_age != 4'hf)
      b_age <= b_age + 4'h1;
  end
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always_ff @(posedge aclk) begin
      if (!aresetn)
        pin_age[g] <= 4'hf;
      else if (event_input_pin[g] != pin_q[g])
        pin_age[g] <= 4'h0;
      else if (pin_age[g] != 4'hf)
        pin_age[g] <= pin_age[g] + 4'h1;
      if (!aresetn)
        irq_age[g] <= 4'hf;
      else if (channel_interrupt[g])
        irq_age[g] <= 4'h0;
      else if (irq_age[g] != 4'hf)
        irq_age[g] <= irq_age[g] + 4'h1;
    end
    property p_irq_cause;
      channel_interrupt[g] |-> pin_age[g] < 4'hc;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without edge");
    property p_out_cause;
      $changed(timer_out[g]) |-> irq_age[g] < 4'h4 || b_age < 4'h4;
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("stray toggle");
  end
  property p_irq_pulse;
    (channel_interrupt & $past(channel_interrupt)) == 4'h0;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_quiet_start;
    $rose(aresetn) |-> (channel_interrupt == 4'h0 && timer_out == 4'h0) [*2];
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("not idle");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("bresp dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read late");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write late");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("ar accepted");
  c_irq: cover property (|channel_interrupt);
  c_toggle: cover property ($changed(timer_out));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // ecfd_sva
`default_nettype wire

// *** testbench/ecfd_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecfd_top_bench
  import ecfd_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  event_input_pin, timer_out, channel_interrupt, src_mask, out_q = 4'h0;
  logic [7:0]  src_n;
  logic        src_go, src_busy;
  int          err_total = 0, checked = 0, cyc = 0;
  int          irq_n [4] = '{0, 0, 0, 0};
  int          tog_n [4] = '{0, 0, 0, 0};
  int          b_irq [4], b_tog [4];
  always #10 aclk = ~aclk;
  ecfd_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .event_input_pin, .timer_out, .channel_interrupt);
  ecfd_src u_src (.aclk, .go(src_go), .mask(src_mask), .n_pulses(src_n), .busy(src_busy),
    .event_input_pin);
  // ****************************************
  // monitors and watchdog
  // ****************************************
  always @(negedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      irq_n[i] += int'(channel_interrupt[i]);
      tog_n[i] += int'(timer_out[i] !== out_q[i]);
    end
    out_q = timer_out;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done, aw_t, w_t;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      done = s_axi_bvalid;
      r = s_axi_bresp;
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!done);
    s_axi_bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic done, ar_t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      ar_t = s_axi_arvalid && s_axi_arready;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!done);
    s_axi_rready <= 1'b0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic pulse(input logic [3:0] m, input logic [7:0] n);
    @(posedge aclk);
    src_go <= 1'b1;
    src_mask <= m;
    src_n <= n;
    @(posedge aclk);
    src_go <= 1'b0;
    do @(negedge aclk); while (src_busy);
    repeat (12) @(negedge aclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rc(8'h48, 32'h0);
    wr(8'h44, 32'h1234, RESP_OKAY);
    wr(OFF_PERIPH, 32'h1, RESP_OKAY);
    rc(8'h44, 32'h0);
    rc(8'h48, 32'hffff);
    wr(8'h28, 32'h1, RESP_SLVERR);
    wr(OFF_PRESCALE, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_event();
    wr(OFF_TOGGLE_EN, 32'h0, RESP_OKAY);
    wr(OFF_OUT_POL, 32'h0, RESP_OKAY);
    wr(OFF_FILTER, 32'h0, RESP_OKAY);
    wr(8'h50, 32'h14, RESP_OKAY);
    wr(8'h54, 32'h3, RESP_OKAY);
    b_irq = irq_n;
    wr(OFF_START, 32'h2, RESP_OKAY);
    rc(OFF_START, 32'h0);
    rc(OFF_ACTIVE, 32'h2);
    rc(8'h58, 32'h3);
    pulse(4'h2, 8'd2);
    rc(8'h58, 32'h1);
    wr(8'h54, 32'h5, RESP_OKAY);
    pulse(4'h2, 8'd2);
    rc(8'h58, 32'h5);
    chk(irq_n[1] - b_irq[1], 32'h1);
    wr(OFF_STOP, 32'h2, RESP_OKAY);
    rc(OFF_ACTIVE, 32'h0);
    pulse(4'h2, 8'd2);
    rc(8'h58, 32'h5);
    $display("test event done");
  endtask
  task automatic t_div();
    wr(8'h40, 32'h25, RESP_OKAY);
    wr(8'h60, 32'h24, RESP_OKAY);
    wr(8'h70, 32'h24, RESP_OKAY);
    wr(8'h44, 32'h1, RESP_OKAY);
    wr(8'h64, 32'h1, RESP_OKAY);
    wr(8'h74, 32'h1, RESP_OKAY);
    wr(OFF_TOGGLE_EN, 32'hd, RESP_OKAY);
    b_tog = tog_n;
    b_irq = irq_n;
    wr(OFF_START, 32'hd, RESP_OKAY);
    pulse(4'hd, 8'd5);
    chk(tog_n[0] - b_tog[0], 32'h3);
    chk(irq_n[0] - b_irq[0], 32'h3);
    chk(tog_n[3] - b_tog[3], 32'h2);
    chk(irq_n[3] - b_irq[3], 32'h2);
    chk(tog_n[2] - b_tog[2], 32'h0);
    wr(OFF_STOP, 32'hd, RESP_OKAY);
    pulse(4'hd, 8'd2);
    chk({28'h0, timer_out}, 32'h1);
    wr(8'h70, 32'h28, RESP_OKAY);
    b_tog = tog_n;
    wr(OFF_START, 32'h8, RESP_OKAY);
    pulse(4'h8, 8'd3);
    chk(tog_n[3] - b_tog[3], 32'h2);
    wr(OFF_STOP, 32'h8, RESP_OKAY);
    wr(OFF_TOGGLE_EN, 32'h0, RESP_OKAY);
    wr(OFF_OUT_LEVEL, 32'h8, RESP_OKAY);
    repeat (3) @(negedge aclk);
    chk({28'h0, timer_out}, 32'h8);
    $display("test divider done");
  endtask
  task automatic t_unit_off();
    wr(OFF_PERIPH, 32'h0, RESP_OKAY);
    wr(OFF_PERIPH, 32'h1, RESP_OKAY);
    rc(8'h54, 32'h0);
    rc(8'h58, 32'hffff);
    rc(OFF_OUT_LEVEL, 32'h0);
    chk({28'h0, timer_out}, 32'h0);
    wr(8'h50, 32'h114, RESP_OKAY);
    wr(8'h54, 32'h1, RESP_OKAY);
    wr(OFF_START, 32'h2, RESP_OKAY);
    pulse(4'h2, 8'd1);
    rc(8'h58, 32'hff00);
    $display("test unit off done");
  endtask
  task automatic conclude();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, src_go} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, src_n} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    src_mask = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_event();
    t_div();
    t_unit_off();
    conclude();
  end
endmodule // ecfd_top_bench
bind ecfd_top ecfd_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .event_input_pin, .timer_out, .channel_interrupt);
`default_nettype wire
